// [bms_battery_mode_sequencer.sv]
// Battery mode sequencer: operating mode machine, power event flags
// with interrupt, APB register slave and processor clock enable.
// Assumes all pin inputs are asynchronous to pclk.
//
// Overview of operation
// - Mains present and PLL locked puts the device in normal mode.
// - Supply fault below bias keeps the device in one battery mode.
// - Supply fault or battery wake enters reduced mode without firmware.
// - Firmware request bits move reduced mode to display-only or standby.
// - Normal to reduced transition sets the PLL fall flag, bit 7.
// - Return to normal with PLL stable sets the PLL rise flag, bit 6.
// - Standby request is bit 6 of the control byte; it leaves reduced.
// - Without mains, display-only and standby return to reduced only on wake or button.
// - Pushbutton going high sets the button event flag, bit 4.
// - Wake timer expiry sets the wake timeout flag, bit 5.
// - Lost regulator margin without mains forces deep standby.
// - Forced standby persists even after margin returns.
// - Restored mains moves any battery mode to normal once PLL settles.
// - Reduced mode clocks processor at 7/8; divider ignored but kept.
// - PLL unlocked holds engine enables low; lock fall clears engine PC.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

module bms_battery_mode_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bms_pkg::bms_pins_t pins_async,
  output bms_pkg::bms_mode_t mode,
  output logic forced_standby,
  output logic irq,
  output logic adc_enable,
  output logic ce_enable,
  output logic ce_pc_clear,
  output logic cpu_clk_en
);
  import bms_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] meta_reg;
  logic [PIN_W-1:0] sync_reg;
  logic [PIN_W-1:0] prev_reg;
  wire logic [PIN_W-1:0] pins_vec = pins_async;

  // Two flops per pin, third one only for edge detection
  for (genvar g = 0; g < PIN_W; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_reg[g] <= 1'b0;
        sync_reg[g] <= 1'b0;
        prev_reg[g] <= 1'b0;
      end else begin
        meta_reg[g] <= pins_vec[g];
        sync_reg[g] <= meta_reg[g];
        prev_reg[g] <= sync_reg[g];
      end
    end
  end

  bms_pins_t pin_s;
  bms_pins_t pin_p;
  assign pin_s = sync_reg;
  assign pin_p = prev_reg;

  // Events seen on the synchronised pins
  wire logic supply_low = pin_s.below_bias_threshold;
  wire logic margin_ok = pin_s.regulator_margin_good;
  wire logic button_rise = pin_s.pushbutton_input & ~pin_p.pushbutton_input;
  wire logic wake_rise = pin_s.wake_timer_expired & ~pin_p.wake_timer_expired;
  wire logic lock_fall = ~pin_s.pll_lock & pin_p.pll_lock;
  wire logic wake_event = button_rise | wake_rise;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [7:0] flags_reg;
  logic [7:0] mask_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] engine_reg;
  logic [7:0] clk_cnt_reg;

  wire logic setup = psel & ~penable;
  wire logic access = psel & penable & pready;
  wire logic hit_flags = paddr == ADDR_FLAGS;
  wire logic hit_mask = paddr == ADDR_MASK;
  wire logic hit_status = paddr == ADDR_STATUS;
  wire logic hit_engine = paddr == ADDR_ENGINE;
  wire logic hit_ctrl = paddr == ADDR_CTRL;
  wire logic mapped = hit_flags | hit_mask | hit_status | hit_engine | hit_ctrl;
  wire logic wr_mask = access & pwrite & hit_mask;
  wire logic wr_engine = access & pwrite & hit_engine;
  wire logic wr_ctrl = access & pwrite & hit_ctrl;
  wire logic rd_flags = access & ~pwrite & hit_flags;

  // Read data, bits above the byte read as zero
  wire logic [7:0] status_byte = {4'h0, forced_standby, pin_s.pll_lock, mode};
  wire logic [7:0] rdata_byte = hit_flags ? flags_reg :
                                hit_mask ? mask_reg :
                                hit_status ? status_byte :
                                hit_engine ? engine_reg :
                                hit_ctrl ? ctrl_reg : 8'h00;

  // Ready in the access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup && !pwrite ? {24'h00_0000, rdata_byte} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Operating mode machine
  // ---------------------------------------------------------------
  bms_mode_t mode_next;
  logic forced_next;

  always_comb begin
    mode_next = mode;
    forced_next = forced_standby;
    if (!supply_low) begin
      if (pin_s.pll_lock) begin
        mode_next = normal_mode;
        forced_next = 1'b0;
      end
    end else begin
      unique case (mode)
        normal_mode: begin
          mode_next = reduced_battery_mode;
        end
        reduced_battery_mode: begin
          if (!margin_ok) begin
            mode_next = deep_standby_mode;
            forced_next = 1'b1;
          end else if (ctrl_reg[STANDBY_BIT]) begin
            mode_next = deep_standby_mode;
          end else if (ctrl_reg[DISPLAY_BIT]) begin
            mode_next = display_only_mode;
          end
        end
        display_only_mode: begin
          if (!margin_ok) begin
            mode_next = deep_standby_mode;
            forced_next = 1'b1;
          end else if (wake_event) begin
            mode_next = reduced_battery_mode;
          end
        end
        deep_standby_mode: begin
          if (!margin_ok) begin
            forced_next = 1'b1;
          end else if (!forced_standby && wake_event) begin
            mode_next = reduced_battery_mode;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= normal_mode;
      forced_standby <= 1'b0;
    end else begin
      mode <= mode_next;
      forced_standby <= forced_next;
    end
  end

  // ---------------------------------------------------------------
  // Event flags, mask and interrupt
  // ---------------------------------------------------------------
  wire logic fall_set = (mode == normal_mode) && (mode_next == reduced_battery_mode);
  wire logic rise_set = (mode != normal_mode) && (mode_next == normal_mode);
  logic [7:0] flag_set;
  logic [7:0] flags_next;
  logic [7:0] mask_next;
  logic [7:0] ctrl_next;

  always_comb begin
    flag_set = 8'h00;
    flag_set[FALL_BIT] = fall_set;
    flag_set[RISE_BIT] = rise_set;
    flag_set[WAKE_BIT] = wake_rise;
    flag_set[BUTTON_BIT] = button_rise;
  end

  // Read clears only the bits reported; a new set wins
  assign flags_next = ((flags_reg & ~(rd_flags ? prdata[7:0] : 8'h00)) | flag_set) & FLAG_MASK;
  assign mask_next = wr_mask ? (pwdata[7:0] & FLAG_MASK) : mask_reg;

  // Requests drop once acted on; a write in that cycle wins
  assign ctrl_next = wr_ctrl ? (pwdata[7:0] & CTRL_MASK) :
                     (mode == reduced_battery_mode && mode_next != reduced_battery_mode) ?
                     RESET_BYTE : ctrl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= RESET_BYTE;
      mask_reg <= RESET_BYTE;
      ctrl_reg <= RESET_BYTE;
      irq <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      irq <= |(flags_next & mask_next);
    end
  end

  // ---------------------------------------------------------------
  // Engine enables and processor clock enable
  // ---------------------------------------------------------------
  wire logic [DIV_W-1:0] processor_clock_divider = engine_reg[DIV_LSB +: DIV_W];
  wire logic [7:0] div_mask = ~(8'hff << processor_clock_divider);
  wire logic normal_tick = (clk_cnt_reg & div_mask) == 8'h00;
  wire logic reduced_tick = clk_cnt_reg[2:0] != REDUCED_SKIP;
  wire logic cpu_tick = (mode == normal_mode) ? normal_tick :
                        (mode == reduced_battery_mode) ? reduced_tick : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_reg <= RESET_BYTE;
      clk_cnt_reg <= 8'h00;
      cpu_clk_en <= 1'b0;
    end else begin
      if (wr_engine) begin
        engine_reg <= pwdata[7:0] & ENGINE_MASK;
      end
      clk_cnt_reg <= clk_cnt_reg + 8'h01;
      cpu_clk_en <= cpu_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_enable <= 1'b0;
      ce_enable <= 1'b0;
      ce_pc_clear <= 1'b0;
    end else begin
      adc_enable <= engine_reg[ADC_BIT] & pin_s.pll_lock;
      ce_enable <= engine_reg[CE_BIT] & pin_s.pll_lock;
      ce_pc_clear <= lock_fall;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  normal_entry_a: assert property (!supply_low && pin_s.pll_lock |=> mode == normal_mode)
    else $error("normal mode not entered");
  battery_mode_a: assert property (supply_low |=> mode != normal_mode)
    else $error("normal mode while supply low");
  auto_reduced_a: assert property (mode == normal_mode && supply_low
    |=> mode == reduced_battery_mode)
    else $error("reduced mode not entered");
  display_request_a: assert property (mode == reduced_battery_mode && supply_low
    && margin_ok && ctrl_reg[DISPLAY_BIT] && !ctrl_reg[STANDBY_BIT]
    |=> mode == display_only_mode)
    else $error("display request ignored");
  fall_flag_a: assert property (mode == reduced_battery_mode && $past(mode) == normal_mode
    |-> flags_reg[FALL_BIT])
    else $error("fall flag missing");
  rise_flag_a: assert property (mode == normal_mode && $past(mode) != normal_mode
    |-> flags_reg[RISE_BIT])
    else $error("rise flag missing");
  standby_request_a: assert property (mode == reduced_battery_mode && supply_low
    && ctrl_reg[STANDBY_BIT] |=> mode == deep_standby_mode)
    else $error("standby request ignored");
  exit_cause_a: assert property (mode == reduced_battery_mode
    && ($past(mode) == display_only_mode || $past(mode) == deep_standby_mode)
    |-> $past(wake_event))
    else $error("low power exit without wake");
  button_flag_a: assert property (button_rise
    |=> flags_reg[BUTTON_BIT] && (irq || !mask_reg[BUTTON_BIT]))
    else $error("button flag missing");
  wake_flag_a: assert property (wake_rise |=> flags_reg[WAKE_BIT])
    else $error("wake flag missing");
  forced_entry_a: assert property (supply_low && !margin_ok && mode != normal_mode
    |=> mode == deep_standby_mode && forced_standby)
    else $error("forced standby missing");
  forced_hold_a: assert property (supply_low && forced_standby && mode == deep_standby_mode
    |=> mode == deep_standby_mode)
    else $error("forced standby left");
  reduced_clock_a: assert property (mode == reduced_battery_mode
    && clk_cnt_reg[2:0] == REDUCED_SKIP |=> !cpu_clk_en)
    else $error("skip slot clocked");
  engine_gate_a: assert property (!pin_s.pll_lock |=> !adc_enable && !ce_enable)
    else $error("engine enabled unlocked");

endmodule : bms_battery_mode_sequencer

`default_nettype wire

// [bms_pkg.sv]
// Constants, register map and carrier types of the battery mode sequencer.
// Assumes a 16-bit APB byte address and 32-bit data.
`default_nettype none

package bms_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] IDX_FLAGS = 16'h00e8;
  localparam logic [15:0] IDX_MASK = 16'h00e9;
  localparam logic [15:0] IDX_STATUS = 16'h00ea;
  localparam logic [15:0] IDX_ENGINE = 16'h00eb;
  localparam logic [15:0] IDX_CTRL = 16'h20a9;
  localparam logic [15:0] ADDR_FLAGS = {IDX_FLAGS[13:0], 2'b00};
  localparam logic [15:0] ADDR_MASK = {IDX_MASK[13:0], 2'b00};
  localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};
  localparam logic [15:0] ADDR_ENGINE = {IDX_ENGINE[13:0], 2'b00};
  localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};

  // ---------------------------------------------------------------
  // Field positions and writable masks
  // ---------------------------------------------------------------
  localparam int FALL_BIT = 7;
  localparam int RISE_BIT = 6;
  localparam int WAKE_BIT = 5;
  localparam int BUTTON_BIT = 4;
  localparam logic [7:0] FLAG_MASK = 8'hf0;
  localparam int STANDBY_BIT = 6;
  localparam int DISPLAY_BIT = 5;
  localparam logic [7:0] CTRL_MASK = 8'h60;
  localparam int ADC_BIT = 0;
  localparam int CE_BIT = 1;
  localparam int DIV_LSB = 4;
  localparam int DIV_W = 3;
  localparam logic [7:0] ENGINE_MASK = 8'h73;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Processor clock: one slot in eight skipped in reduced_battery_mode
  localparam logic [2:0] REDUCED_SKIP = 3'h7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    normal_mode,
    reduced_battery_mode,
    display_only_mode,
    deep_standby_mode
  } bms_mode_t;

  // Asynchronous supply monitor and wake inputs
  typedef struct packed {
    logic below_bias_threshold;
    logic pll_lock;
    logic regulator_margin_good;
    logic pushbutton_input;
    logic wake_timer_expired;
  } bms_pins_t;

  localparam int PIN_W = 5;

endpackage : bms_pkg

`default_nettype wire

// [bms_supply_model.sv]
// Supply monitor model: mains comparator, PLL lock, regulator margin and wake pins.
// Assumes the bench sets mains, margin, button and wake levels off the clock edge.
`timescale 1ns/1ps
`default_nettype none

module bms_supply_model
  import bms_pkg::*;
#(
  parameter int SETTLE = 6
) (
  input wire logic pclk,
  input wire logic mains_on,
  input wire logic margin_ok,
  input wire logic button,
  input wire logic wake,
  output bms_pkg::bms_pins_t pins
);
  // ---------------------------------------------------------------
  // PLL settling
  // ---------------------------------------------------------------
  int settle_cnt = 0;

  always @(posedge pclk) begin
    if (!mains_on) begin
      settle_cnt <= 0;
    end else if (settle_cnt < SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end
  end

  // Lock drops at once with mains, rises only after settling
  assign pins.below_bias_threshold = !mains_on;
  assign pins.pll_lock = mains_on && (settle_cnt >= SETTLE);
  assign pins.regulator_margin_good = margin_ok;
  assign pins.pushbutton_input = button;
  assign pins.wake_timer_expired = wake;
endmodule : bms_supply_model

`default_nettype wire

// [bms_battery_mode_sequencer_tb.sv]
// Testbench of the battery mode sequencer: APB master, read monitor and mode scenarios.
// Assumes the design package, the design and the supply model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bms_battery_mode_sequencer_tb;
  import bms_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] mode_o;
  logic forced_o;
  logic adc_en;
  logic ce_en;
  logic pc_clr;
  logic clk_en;
  int n_pc_clr = 0;
  logic mains_on = 1'b1;
  logic margin_ok = 1'b1;
  logic button = 1'b0;
  logic wake = 1'b0;
  bms_pins_t pins;
  logic [32:0] exp_q[$];
  logic [31:0] rnd = 32'h1112;
  int miscompares = 0;
  int n_compared = 0;

  // Clock of 100 ns period
  always #50 pclk = ~pclk;

  bms_supply_model i_bms_supply_model (.pclk(pclk), .mains_on(mains_on),
    .margin_ok(margin_ok), .button(button), .wake(wake), .pins(pins));

  bms_battery_mode_sequencer i_bms_battery_mode_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_async(pins), .mode(mode_o),
    .forced_standby(forced_o), .irq(irq), .adc_enable(adc_en), .ce_enable(ce_en),
    .ce_pc_clear(pc_clr), .cpu_clk_en(clk_en));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Expected status word with no bus error
  function automatic logic [32:0] st(input bms_mode_t m, input logic lk, input logic fs);
    return {1'b0, 28'h0000000, fs, lk, m};
  endfunction : st

  // One APB transfer; a read notes its expected answer first
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    apb(1'b0, a, '0, e);
  endtask : rd

  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask : settle

  task automatic check_read(input logic [32:0] e);
    n_compared++;
    if ({pslverr, prdata} !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t read %h expected %h", $time, {pslverr, prdata}, e);
    end
  endtask : check_read

  task automatic chk_irq(input logic e);
    repeat (2) @(negedge pclk);
    n_compared++;
    if (irq !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t irq %b expected %b", $time, irq, e);
    end
  endtask : chk_irq

  // Level outputs: mode, forced standby and the two engine enables
  task automatic chk_lvl(input bms_mode_t m, input logic fs, input logic en);
    repeat (2) @(negedge pclk);
    n_compared++;
    if ({mode_o, forced_o, adc_en, ce_en} !== {m, fs, en, en}) begin
      miscompares++;
      $display("MISMATCH t=%0t outputs %b expected %b", $time,
        {mode_o, forced_o, adc_en, ce_en}, {m, fs, en, en});
    end
  endtask : chk_lvl

  // Count of pulses seen on an output
  task automatic chk_num(input int got, input int e);
    n_compared++;
    if (got != e) begin
      miscompares++;
      $display("MISMATCH t=%0t count %0d expected %0d", $time, got, e);
    end
  endtask : chk_num

  // Processor clock enables over eight cycles
  task automatic count_clk(input int e);
    int n;
    n = 0;
    repeat (8) begin
      @(negedge pclk);
      if (clk_en === 1'b1) n++;
    end
    chk_num(n, e);
  endtask : count_clk

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Engine program counter clears seen so far
  always @(negedge pclk) begin
    if (pc_clr === 1'b1) n_pc_clr++;
  end

  // Read monitor takes the oldest note at each read answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check_read(exp_q.pop_front());
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("MISMATCH t=%0t watchdog", $time);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rd(ADDR_STATUS, st(normal_mode, 1'b1, 1'b0));
    rd(ADDR_FLAGS, '0);
    wr(ADDR_STATUS, 32'h000000ff);
    rd(ADDR_STATUS, st(normal_mode, 1'b1, 1'b0));
    rd(16'h0010, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      rnd = xorshift(rnd);
      wr(ADDR_ENGINE, rnd);
      rd(ADDR_ENGINE, {25'h0, rnd[7:0] & ENGINE_MASK});
    end
    wr(ADDR_ENGINE, 32'h00000033);
    chk_lvl(normal_mode, 1'b0, 1'b1);
    count_clk(1);
    $display("test registers done");
    wr(ADDR_MASK, 32'h000000f0);
    @(posedge pclk);
    mains_on <= 1'b0;
    settle();
    chk_irq(1'b1);
    rd(ADDR_STATUS, st(reduced_battery_mode, 1'b0, 1'b0));
    rd(ADDR_FLAGS, 33'h080);
    rd(ADDR_FLAGS, '0);
    chk_irq(1'b0);
    chk_lvl(reduced_battery_mode, 1'b0, 1'b0);
    count_clk(7);
    chk_num(n_pc_clr, 1);
    $display("test mains loss done");
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, (k != 0) ? 32'h60 : 32'h20);
      settle();
      rd(ADDR_STATUS, st((k != 0) ? deep_standby_mode : display_only_mode, 1'b0, 1'b0));
      rd(ADDR_CTRL, '0);
      chk_lvl((k != 0) ? deep_standby_mode : display_only_mode, 1'b0, 1'b0);
      @(posedge pclk);
      button <= (k == 0);
      wake <= (k != 0);
      settle();
      rd(ADDR_STATUS, st(reduced_battery_mode, 1'b0, 1'b0));
      wr(ADDR_MASK, 32'h0);
      chk_irq(1'b0);
      wr(ADDR_MASK, 32'hf0);
      chk_irq(1'b1);
      rd(ADDR_FLAGS, (k != 0) ? 33'h020 : 33'h010);
      @(posedge pclk);
      button <= 1'b0;
      wake <= 1'b0;
      settle();
    end
    $display("test battery modes done");
    @(posedge pclk);
    margin_ok <= 1'b0;
    settle();
    rd(ADDR_STATUS, st(deep_standby_mode, 1'b0, 1'b1));
    chk_lvl(deep_standby_mode, 1'b1, 1'b0);
    @(posedge pclk);
    margin_ok <= 1'b1;
    button <= 1'b1;
    settle();
    rd(ADDR_STATUS, st(deep_standby_mode, 1'b0, 1'b1));
    rd(ADDR_FLAGS, 33'h010);
    @(posedge pclk);
    button <= 1'b0;
    mains_on <= 1'b1;
    settle();
    rd(ADDR_STATUS, st(normal_mode, 1'b1, 1'b0));
    rd(ADDR_FLAGS, 33'h040);
    chk_lvl(normal_mode, 1'b0, 1'b1);
    chk_num(n_pc_clr, 1);
    @(negedge pclk);
    $display("test forced standby done");
    tally_and_finish();
  end
endmodule : bms_battery_mode_sequencer_tb

`default_nettype wire
